// ### src/tbs_pkg.sv
// Constants and types for the timer readback and test bus select block
package tbs_pkg;
    localparam int TBS_ADDR_W = 6;
    localparam int TBS_DATA_W = 8;
    localparam logic [5:0] TBS_ADDR_COUNT_HIGH = 6'h2E;
    localparam logic [5:0] TBS_ADDR_COUNT_LOW = 6'h2F;
    localparam logic [5:0] TBS_ADDR_RESERVED = 6'h30;
    localparam logic [5:0] TBS_ADDR_BIT_SELECT = 6'h31;
    localparam logic [5:0] TBS_ADDR_BUS_CONTROL = 6'h32;
    localparam logic [7:0] TBS_RESET_BIT_SELECT = 8'h00;
    localparam logic [7:0] TBS_RESET_BUS_CONTROL = 8'h00;
    localparam logic [7:0] TBS_READ_ZERO = 8'h00;
    localparam int TBS_BIT_SELECT_MSB = 2;
    localparam int TBS_FLIP_BIT = 7;
    localparam int TBS_NINE_BIT = 6;
    localparam int TBS_FIFTEEN_BIT = 5;
    localparam int TBS_GROUP_MSB = 4;
    localparam logic [7:0] TBS_AUX_ROUTE_PROBE = 8'hFF;
    localparam logic [14:0] TBS_PRBS_SEED = 15'h7FFF;
    localparam int TBS_PSEUDO_RANDOM_NINE_ENABLE_TAP_A = 8;
    localparam int TBS_PSEUDO_RANDOM_NINE_ENABLE_TAP_B = 4;
    localparam int TBS_PSEUDO_RANDOM_FIFTEEN_ENABLE_TAP_A = 14;
    localparam int TBS_PSEUDO_RANDOM_FIFTEEN_ENABLE_TAP_B = 13;

    typedef enum logic [1:0]
    {
        TBS_PRBS_OFF = 2'b00,
        TBS_PRBS_NINE = 2'b01,
        TBS_PRBS_FIFTEEN = 2'b10
    } tbs_prbs_mode_t;
endpackage : tbs_pkg

// ### src/tbs_prbs_if.sv
// Link between the register bank and the sequence generator
`timescale 1ns/1ns
`default_nettype none
interface tbs_prbs_if;
    logic nine_enable;
    logic fifteen_enable;
    logic seq_bit;
    logic seq_active;

    modport bank
    (
        output nine_enable,
        output fifteen_enable,
        input seq_bit,
        input seq_active
    );

    modport gen
    (
        input nine_enable,
        input fifteen_enable,
        output seq_bit,
        output seq_active
    );
endinterface : tbs_prbs_if
`default_nettype wire

// ### src/tbs_prbs_gen.sv
// Nine and fifteen stage pseudo-random sequence generator
`timescale 1ns/1ns
`default_nettype none
module tbs_prbs_gen
    import tbs_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    tbs_prbs_if.gen link
);
    tbs_prbs_mode_t mode;
    tbs_prbs_mode_t last_mode;
    logic [14:0] state;
    logic [14:0] next_state;
    logic next_bit;

    // Nine stage wins when both are set
    always_comb
    begin
        if (link.nine_enable)
        begin
            mode = TBS_PRBS_NINE;
        end
        else if (link.fifteen_enable)
        begin
            mode = TBS_PRBS_FIFTEEN;
        end
        else
        begin
            mode = TBS_PRBS_OFF;
        end
    end

    always_comb
    begin
        next_state = state;
        next_bit = 1'b0;
        case (mode)
            TBS_PRBS_NINE:
            begin
                next_bit = state[TBS_PSEUDO_RANDOM_NINE_ENABLE_TAP_A] ^ state[TBS_PSEUDO_RANDOM_NINE_ENABLE_TAP_B];
                next_state = {6'h00, state[7:0], next_bit};
            end
            TBS_PRBS_FIFTEEN:
            begin
                next_bit = state[TBS_PSEUDO_RANDOM_FIFTEEN_ENABLE_TAP_A] ^ state[TBS_PSEUDO_RANDOM_FIFTEEN_ENABLE_TAP_B];
                next_state = {state[13:0], next_bit};
            end
            default:
            begin
                next_state = TBS_PRBS_SEED;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state <= TBS_PRBS_SEED;
            last_mode <= TBS_PRBS_OFF;
            link.seq_bit <= 1'b0;
            link.seq_active <= 1'b0;
        end
        else
        begin
            last_mode <= mode;
            link.seq_active <= (mode != TBS_PRBS_OFF);
            if (mode != last_mode)
            begin
                state <= TBS_PRBS_SEED;
                link.seq_bit <= 1'b0;
            end
            else
            begin
                state <= next_state;
                link.seq_bit <= next_bit;
            end
        end
    end
endmodule : tbs_prbs_gen
`default_nettype wire

// ### src/tbs_test_regs.sv
// Timer readback, reserved slot and test bus select registers
`timescale 1ns/1ns
`default_nettype none
// Operation
// - Register 2Eh reads upper byte of live timer count; no reset value.
// - Register 2Fh reads lower byte of live timer count; no reset value.
// - Upper byte read returns count bits fifteen down to eight.
// - Lower byte read returns count bits seven down to zero.
// - Register 30h is reserved; reads zero, writes ignored.
// - Register 31h resets to zero; bits 2:0 select a bit, rest reserved.
// - Selected test bus bit drives the card interface output pin.
// - Aux route field all ones also puts that bit on auxiliary pins.
// - Register 32h resets zero: flip, nine, fifteen, five-bit group select.
// - Flip set maps test bus to parallel port in fixed other order.
// - Register 32h mixes test configuration and sequence generator control.
// - Nine enable starts transmitter emitting nine-stage pseudo-random sequence.
module tbs_test_regs
    import tbs_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [5:0] reg_addr,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic [15:0] timer_count,
    input wire logic [7:0] test_bus,
    input wire logic [7:0] analog_aux_route_select,
    output logic [4:0] probe_group_select,
    output logic card_interface_output_pin,
    output logic auxiliary_pin_one,
    output logic auxiliary_pin_two,
    output logic [7:0] parallel_port,
    output logic tx_prbs_bit,
    output logic tx_prbs_active
);
    logic [2:0] probe_bit_select;
    logic probe_order_reverse;
    logic pseudo_random_nine_enable;
    logic pseudo_random_fifteen_enable;
    logic [7:0] next_rdata;
    logic [7:0] count_upper_byte;
    logic [7:0] count_lower_byte;

    tbs_prbs_if prbs_link ();

    function automatic logic pick_bit(input logic [7:0] bus, input logic [2:0] sel);
        pick_bit = bus[sel];
    endfunction : pick_bit

    // Alternative pin order used when the bus is flipped
    function automatic logic [7:0] flip_order(input logic [7:0] bus);
        flip_order = {bus[7], bus[1], bus[4], bus[3], bus[2], bus[6], bus[5], bus[0]};
    endfunction : flip_order

    assign count_upper_byte = timer_count[15:8];
    assign count_lower_byte = timer_count[7:0];

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            probe_bit_select <= TBS_RESET_BIT_SELECT[TBS_BIT_SELECT_MSB:0];
        end
        else if (reg_write && reg_addr == TBS_ADDR_BIT_SELECT)
        begin
            probe_bit_select <= reg_wdata[TBS_BIT_SELECT_MSB:0];
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            probe_order_reverse <= TBS_RESET_BUS_CONTROL[TBS_FLIP_BIT];
            pseudo_random_nine_enable <= TBS_RESET_BUS_CONTROL[TBS_NINE_BIT];
            pseudo_random_fifteen_enable <= TBS_RESET_BUS_CONTROL[TBS_FIFTEEN_BIT];
            probe_group_select <= TBS_RESET_BUS_CONTROL[TBS_GROUP_MSB:0];
        end
        else if (reg_write && reg_addr == TBS_ADDR_BUS_CONTROL)
        begin
            probe_order_reverse <= reg_wdata[TBS_FLIP_BIT];
            pseudo_random_nine_enable <= reg_wdata[TBS_NINE_BIT];
            pseudo_random_fifteen_enable <= reg_wdata[TBS_FIFTEEN_BIT];
            probe_group_select <= reg_wdata[TBS_GROUP_MSB:0];
        end
    end

    // read decode, reserved and unmapped read zero
    always_comb
    begin
        next_rdata = TBS_READ_ZERO;
        case (reg_addr)
            TBS_ADDR_COUNT_HIGH:
            begin
                next_rdata = count_upper_byte;
            end
            TBS_ADDR_COUNT_LOW:
            begin
                next_rdata = count_lower_byte;
            end
            TBS_ADDR_BIT_SELECT:
            begin
                next_rdata = {5'h00, probe_bit_select};
            end
            TBS_ADDR_BUS_CONTROL:
            begin
                next_rdata = {probe_order_reverse, pseudo_random_nine_enable,
                              pseudo_random_fifteen_enable, probe_group_select};
            end
            default:
            begin
                next_rdata = TBS_READ_ZERO;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            reg_rdata <= TBS_READ_ZERO;
            reg_rvalid <= 1'b0;
        end
        else
        begin
            reg_rvalid <= reg_read;
            if (reg_read)
            begin
                reg_rdata <= next_rdata;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            card_interface_output_pin <= 1'b0;
            auxiliary_pin_one <= 1'b0;
            auxiliary_pin_two <= 1'b0;
        end
        else
        begin
            card_interface_output_pin <= pick_bit(test_bus, probe_bit_select);
            if (analog_aux_route_select == TBS_AUX_ROUTE_PROBE)
            begin
                auxiliary_pin_one <= pick_bit(test_bus, probe_bit_select);
                auxiliary_pin_two <= pick_bit(test_bus, probe_bit_select);
            end
            else
            begin
                auxiliary_pin_one <= 1'b0;
                auxiliary_pin_two <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            parallel_port <= 8'h00;
        end
        else if (probe_order_reverse)
        begin
            parallel_port <= flip_order(test_bus);
        end
        else
        begin
            parallel_port <= test_bus;
        end
    end

    // generator control from the bus control register
    assign prbs_link.nine_enable = pseudo_random_nine_enable;
    assign prbs_link.fifteen_enable = pseudo_random_fifteen_enable;

    tbs_prbs_gen u_prbs
    (
        .clk(clk),
        .rst(rst),
        .link(prbs_link.gen)
    );

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            tx_prbs_bit <= 1'b0;
            tx_prbs_active <= 1'b0;
        end
        else
        begin
            tx_prbs_bit <= prbs_link.seq_bit;
            tx_prbs_active <= prbs_link.seq_active;
        end
    end

    chk_upper_byte_read: assert property (
        @(posedge clk) disable iff (rst)
        reg_read && reg_addr == TBS_ADDR_COUNT_HIGH |=> reg_rvalid && reg_rdata == $past(timer_count[15:8]))
        else $error("upper count byte read wrong");

    chk_lower_byte_read: assert property (
        @(posedge clk) disable iff (rst)
        reg_read && reg_addr == TBS_ADDR_COUNT_LOW |=> reg_rvalid && reg_rdata == $past(timer_count[7:0]))
        else $error("lower count byte read wrong");

    chk_count_bytes_split: assert property (
        @(posedge clk) disable iff (rst)
        reg_read && reg_addr == TBS_ADDR_COUNT_HIGH ##1 !reg_read && $stable(timer_count)
        ##1 reg_read && reg_addr == TBS_ADDR_COUNT_LOW && $stable(timer_count)
        |=> {$past(reg_rdata), reg_rdata} == $past(timer_count))
        else $error("count bytes do not join to count");

    chk_reserved_reads_zero: assert property (
        @(posedge clk) disable iff (rst)
        reg_read && reg_addr == TBS_ADDR_RESERVED |=> reg_rdata == 8'h00)
        else $error("reserved slot read not zero");

    chk_bit_select_readback: assert property (
        @(posedge clk) disable iff (rst)
        reg_write && reg_addr == TBS_ADDR_BIT_SELECT ##1 !reg_write
        ##1 reg_read && reg_addr == TBS_ADDR_BIT_SELECT && !reg_write
        |=> reg_rdata == {5'h00, $past(reg_wdata[2:0], 3)})
        else $error("bit select readback wrong");

    chk_probe_pin_bit: assert property (
        @(posedge clk) disable iff (rst)
        reg_write && reg_addr == TBS_ADDR_BIT_SELECT ##1 !reg_write
        |=> {7'h00, card_interface_output_pin} == (($past(test_bus) >> $past(reg_wdata[2:0], 2)) & 8'h01))
        else $error("probe pin does not follow selected bit");

    chk_aux_route_gate: assert property (
        @(posedge clk) disable iff (rst)
        analog_aux_route_select != TBS_AUX_ROUTE_PROBE |=> !auxiliary_pin_one && !auxiliary_pin_two)
        else $error("aux pins driven without route");

    chk_aux_follows_pin: assert property (
        @(posedge clk) disable iff (rst)
        analog_aux_route_select == TBS_AUX_ROUTE_PROBE |=> auxiliary_pin_two == card_interface_output_pin)
        else $error("aux pin differs from probe pin");

    chk_control_readback: assert property (
        @(posedge clk) disable iff (rst)
        reg_write && reg_addr == TBS_ADDR_BUS_CONTROL ##1 !reg_write
        ##1 reg_read && reg_addr == TBS_ADDR_BUS_CONTROL && !reg_write
        |=> reg_rdata == $past(reg_wdata, 3))
        else $error("bus control readback wrong");

    chk_flip_order_map: assert property (
        @(posedge clk) disable iff (rst)
        probe_order_reverse |=> parallel_port == {$past(test_bus[7]), $past(test_bus[1]), $past(test_bus[4]),
            $past(test_bus[3]), $past(test_bus[2]), $past(test_bus[6]), $past(test_bus[5]), $past(test_bus[0])})
        else $error("flipped parallel order wrong");

    chk_prbs_nine_start: assert property (
        @(posedge clk) disable iff (rst)
        $rose(pseudo_random_nine_enable) |-> ##2 tx_prbs_active)
        else $error("nine stage sequence not started");

    chk_prbs_off_idle: assert property (
        @(posedge clk) disable iff (rst)
        (!pseudo_random_nine_enable && !pseudo_random_fifteen_enable) [*3] |-> !tx_prbs_active && !tx_prbs_bit)
        else $error("sequence output while disabled");

    chk_straight_order_map: assert property (
        @(posedge clk) disable iff (rst)
        !probe_order_reverse |=> parallel_port == $past(test_bus))
        else $error("straight parallel order wrong");

    chk_read_valid_pulse: assert property (
        @(posedge clk) disable iff (rst)
        !reg_read |=> !reg_rvalid)
        else $error("read valid without a read");

    chk_group_select_write: assert property (
        @(posedge clk) disable iff (rst)
        reg_write && reg_addr == TBS_ADDR_BUS_CONTROL
        |=> probe_group_select == $past(reg_wdata[TBS_GROUP_MSB:0]))
        else $error("group select not taken from write");

    chk_reserved_write_ignored: assert property (
        @(posedge clk) disable iff (rst)
        reg_write && reg_addr == TBS_ADDR_RESERVED
        |=> $stable(probe_bit_select) && $stable(probe_group_select) && $stable(probe_order_reverse))
        else $error("reserved slot write changed a register");

    chk_reset_defaults: assert property (
        @(posedge clk) disable iff (rst)
        $fell(rst) |-> probe_bit_select == TBS_RESET_BIT_SELECT[TBS_BIT_SELECT_MSB:0]
        && probe_group_select == TBS_RESET_BUS_CONTROL[TBS_GROUP_MSB:0])
        else $error("select registers not cleared by reset");

    chk_prbs_fifteen_start: assert property (
        @(posedge clk) disable iff (rst)
        $rose(pseudo_random_fifteen_enable) && !pseudo_random_nine_enable |-> ##2 tx_prbs_active)
        else $error("fifteen stage sequence not started");
endmodule : tbs_test_regs
`default_nettype wire

// ### bench/tbs_host_model.sv
// Host side model issuing register reads and writes
`timescale 1ns/1ns
`default_nettype none
module tbs_host_model
    import tbs_pkg::*;
(
    input wire logic clk,
    output logic [5:0] reg_addr,
    output logic reg_write,
    output logic reg_read,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid
);
    initial
    begin
        reg_addr = 6'h00;
        reg_write = 1'b0;
        reg_read = 1'b0;
        reg_wdata = 8'h00;
    end

    task automatic write_reg(input logic [5:0] addr, input logic [7:0] data);
        @(posedge clk);
        reg_addr <= addr;
        reg_wdata <= data;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
        // Released data no longer shows the old value
        reg_wdata <= ~data;
    endtask : write_reg

    task automatic read_reg(input logic [5:0] addr, output logic [7:0] data, output logic ok);
        @(posedge clk);
        reg_addr <= addr;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1;
        ok = reg_rvalid;
        data = reg_rdata;
    endtask : read_reg

    task automatic start_nine();
        write_reg(TBS_ADDR_BIT_SELECT, 8'h00);
        write_reg(TBS_ADDR_BUS_CONTROL, 8'h40);
    endtask : start_nine
endmodule : tbs_host_model
`default_nettype wire

// ### bench/test_timer_readback_test_bus_select.sv
// Self-checking bench for the timer readback and test bus select bank
`timescale 1ns/1ns
`default_nettype none
module test_timer_readback_test_bus_select;
    import tbs_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [5:0] reg_addr;
    logic reg_write;
    logic reg_read;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic reg_rvalid;
    logic [15:0] timer_count = 16'h0000;
    logic [7:0] test_bus = 8'h00;
    logic [7:0] aux_route = 8'h00;
    logic [4:0] group_sel;
    logic card_pin;
    logic aux_one;
    logic aux_two;
    logic [7:0] par_port;
    logic prbs_bit;
    logic prbs_active;
    int n_fail = 0;
    int n_checks = 0;
    logic [15:0] lfsr = 16'h0023;

    initial
    begin
        forever #50 clk = ~clk;
    end

    tbs_host_model host (.clk(clk), .reg_addr(reg_addr), .reg_write(reg_write), .reg_read(reg_read),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

    tbs_test_regs i_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_write(reg_write),
        .reg_read(reg_read), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .timer_count(timer_count), .test_bus(test_bus), .analog_aux_route_select(aux_route),
        .probe_group_select(group_sel), .card_interface_output_pin(card_pin),
        .auxiliary_pin_one(aux_one), .auxiliary_pin_two(aux_two), .parallel_port(par_port),
        .tx_prbs_bit(prbs_bit), .tx_prbs_active(prbs_active));

    function automatic logic [7:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr[7:0];
    endfunction : rnd

    function automatic logic [7:0] flip(input logic [7:0] b);
        return {b[7], b[1], b[4], b[3], b[2], b[6], b[5], b[0]};
    endfunction : flip

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : results

    task automatic rd_check(input logic [5:0] addr, input logic [7:0] exp);
        logic [7:0] d;
        logic ok;
        host.read_reg(addr, d, ok);
        check(ok, 1'b1);
        check(d, exp);
    endtask : rd_check

    task automatic wait_active(input logic want);
        int k;
        k = 0;
        while (prbs_active !== want && k < 20)
        begin
            @(posedge clk);
            #1;
            k++;
        end
        check(prbs_active, want);
        if (k == 20)
            results();
    endtask : wait_active

    task automatic pin_step(input logic [2:0] sel, input logic fl, input logic [7:0] route);
        logic [7:0] bus;
        bus = rnd();
        @(posedge clk);
        test_bus <= bus;
        @(posedge clk);
        #1;
        check(card_pin, bus[sel]);
        check(aux_one, (route == 8'hFF) ? bus[sel] : 1'b0);
        check(aux_two, (route == 8'hFF) ? bus[sel] : 1'b0);
        check(par_port, fl ? flip(bus) : bus);
    endtask : pin_step

    initial
    begin : main
        logic [7:0] w;
        logic bits [0:529];
        int ones;
        logic [15:0] cnt;
        logic [7:0] g;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rd_check(TBS_ADDR_BIT_SELECT, TBS_RESET_BIT_SELECT);
        rd_check(TBS_ADDR_BUS_CONTROL, TBS_RESET_BUS_CONTROL);
        check(prbs_active, 1'b0);
        // Live count, boundaries then random, bytes sampled separately
        for (int i = 0; i < 10; i++)
        begin
            cnt = (i == 0) ? 16'hFF00 : (i == 1) ? 16'h00FF : {rnd(), rnd()};
            @(posedge clk);
            timer_count <= cnt;
            rd_check(TBS_ADDR_COUNT_HIGH, cnt[15:8]);
            cnt = {rnd(), rnd()};
            @(posedge clk);
            timer_count <= cnt;
            rd_check(TBS_ADDR_COUNT_LOW, cnt[7:0]);
        end
        // Both bytes of one steady count, read close together
        rd_check(TBS_ADDR_COUNT_HIGH, cnt[15:8]);
        rd_check(TBS_ADDR_COUNT_LOW, cnt[7:0]);
        host.write_reg(TBS_ADDR_COUNT_HIGH, ~timer_count[15:8]);
        rd_check(TBS_ADDR_COUNT_HIGH, timer_count[15:8]);
        host.write_reg(TBS_ADDR_COUNT_LOW, ~timer_count[7:0]);
        rd_check(TBS_ADDR_COUNT_LOW, timer_count[7:0]);
        host.write_reg(TBS_ADDR_RESERVED, 8'hFF);
        rd_check(TBS_ADDR_RESERVED, TBS_READ_ZERO);
        rd_check(6'h3F, TBS_READ_ZERO);
        for (int i = 0; i < 6; i++)
        begin
            w = (i == 0) ? 8'hFF : rnd();
            host.write_reg(TBS_ADDR_BIT_SELECT, w);
            rd_check(TBS_ADDR_BIT_SELECT, {5'h00, w[2:0]});
            w = (i == 0) ? 8'h9F : (rnd() & 8'h9F);
            host.write_reg(TBS_ADDR_BUS_CONTROL, w);
            rd_check(TBS_ADDR_BUS_CONTROL, w);
            check(group_sel, w[4:0]);
        end
        // Every bit select, both orders, aux route on for odd selects and off for even ones
        for (int s = 0; s < 8; s++)
        begin
            for (int f = 0; f < 2; f++)
            begin
                w = s[0] ? 8'hFF : (rnd() & 8'h7F);
                g = rnd();
                host.write_reg(TBS_ADDR_BIT_SELECT, s[7:0]);
                host.write_reg(TBS_ADDR_BUS_CONTROL, {f[0], 2'b00, g[4:0]});
                @(posedge clk);
                aux_route <= w;
                repeat (2) @(posedge clk);
                repeat (3) pin_step(s[2:0], f[0], w);
            end
        end
        host.start_nine();
        rd_check(TBS_ADDR_BUS_CONTROL, 8'h40);
        wait_active(1'b1);
        repeat (3) @(posedge clk);
        ones = 0;
        for (int i = 0; i < 530; i++)
        begin
            @(posedge clk);
            #1;
            bits[i] = prbs_bit;
            if (i < 511 && prbs_bit === 1'b1)
                ones++;
        end
        check(ones[15:0], 16'h0100);
        for (int i = 511; i < 530; i++)
            check(bits[i], bits[i - 511]);
        host.write_reg(TBS_ADDR_BUS_CONTROL, 8'h00);
        wait_active(1'b0);
        host.write_reg(TBS_ADDR_BUS_CONTROL, 8'h20);
        wait_active(1'b1);
        rd_check(TBS_ADDR_BUS_CONTROL, 8'h20);
        results();
    end
endmodule : test_timer_readback_test_bus_select
`default_nettype wire
